// File: include/mlw_fetch_if.sv
// Carrier between the walk sequencer and its memory fetch port.
// Assumes both ends sit on the same clock.
interface mlw_fetch_if;
  logic        req;
  logic [29:0] waddr;
  logic        done;
  logic [31:0] data;
  modport seq (output req, output waddr, input done, input data);
  modport port (input req, input waddr, output done, output data);
endinterface

// File: include/mlw_pkg.sv
// Package for the level-one translation walk block.
// Assumes a single 50 MHz clock domain shared by core and table memory.
package mlw_pkg;
  localparam int DESC_W      = 32;
  localparam int BASE_LO     = 14;
  localparam int VA_IDX_LO   = 20;
  localparam int WADDR_W     = 30;
  localparam int TYPE_HI     = 1;
  localparam int BUF_BIT     = 2;
  localparam int CACHE_BIT   = 3;
  localparam int DOM_LO      = 5;
  localparam int DOM_HI      = 8;
  localparam int AP_LO       = 10;
  localparam int AP_HI       = 11;
  localparam int PT_BASE_LO  = 10;
  localparam int SECT_LO     = 20;
  localparam int SYS_BIT     = 8;
  localparam int ROM_BIT     = 9;
  localparam logic [31:0] TTB_RESET = 32'h0000_0000;

  typedef enum logic [1:0] {
    MLW_DESC_INVALID = 2'h0,
    MLW_DESC_PAGE    = 2'h1,
    MLW_DESC_SECTION = 2'h2,
    MLW_DESC_RSVD    = 2'h3
  } mlw_desc_t;

  typedef enum logic [1:0] {
    MLW_DOM_NONE    = 2'h0,
    MLW_DOM_CLIENT  = 2'h1,
    MLW_DOM_RSVD    = 2'h2,
    MLW_DOM_MANAGER = 2'h3
  } mlw_dom_t;

  typedef enum logic [1:0] {
    MLW_AP_00 = 2'h0,
    MLW_AP_01 = 2'h1,
    MLW_AP_10 = 2'h2,
    MLW_AP_11 = 2'h3
  } mlw_ap_t;

  typedef enum logic [1:0] {
    MLW_RES_OK      = 2'h0,
    MLW_RES_XLATE   = 2'h1,
    MLW_RES_DOMAIN  = 2'h2,
    MLW_RES_PERM    = 2'h3
  } mlw_res_t;
endpackage

// File: testbench/mlw_mem_model.sv
// Table memory model: answers one descriptor read after lag cycles.
// Assumes the walk holds mem_req until mem_ack.
module mlw_mem_model
(
  input  wire logic        clk,
  input  wire logic        mem_req,
  input  wire logic [29:0] mem_waddr,
  input  wire logic [31:0] desc,
  input  wire logic [1:0]  lag,
  output logic             mem_ack,
  output logic [29:0]      seen_addr,
  output logic [31:0]      mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] wait_r = 2'h0;
  assign mem_ack = mem_req && wait_r == lag;
  // Inverse when idle so stale data cannot pass
  assign mem_rdata = mem_ack ? desc : ~desc;
  always @(posedge clk)
  begin
    wait_r <= (mem_req && !mem_ack) ? wait_r + 2'h1 : 2'h0;
    if (mem_ack)
      seen_addr <= mem_waddr;
  end
endmodule // mlw_mem_model

// File: testbench/mlw_walk_chk.sv
// Checker for the level-one walk outputs.
// Assumes it is bound into every mlw_walk instance.
module mlw_walk_chk
(
  input wire logic        clk,
  input wire logic        reset,
  input wire logic [31:0] table_base_reg,
  input wire logic        lookup_valid,
  input wire logic        tlb_hit,
  input wire logic [31:0] va,
  input wire logic        busy,
  input wire logic        mem_req,
  input wire logic [29:0] mem_waddr,
  input wire logic        mem_ack,
  input wire logic [31:0] mem_rdata,
  input wire logic        done,
  input wire logic [1:0]  result,
  input wire logic [3:0]  domain,
  input wire logic        cacheable,
  input wire logic        bufferable,
  input wire logic [31:0] pa,
  input wire logic        l2_req,
  input wire logic [21:0] l2_base
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic [31:0] desc_q;
  always_ff @(posedge clk)
  begin
    if (mem_req && mem_ack)
      desc_q <= mem_rdata;
  end
  chk_hit_no_walk: assert property (lookup_valid && tlb_hit && !busy
    |=> !busy) else $error("walk started on a hit");
  chk_miss_walks: assert property (lookup_valid && !tlb_hit && !busy
    |=> busy && mem_req) else $error("miss did not start a walk");
  chk_base_zero: assert property (table_base_reg[13:0] == 14'h0)
    else $error("table base low bits not zero");
  // Address is captured at the start edge, so compare with those values
  chk_fetch_addr: assert property ($rose(mem_req)
    |-> mem_waddr == {$past(table_base_reg[31:14]), $past(va[31:20])})
    else $error("wrong descriptor address");
  chk_bad_type: assert property (done && !(^desc_q[1:0])
    |-> result == mlw_pkg::MLW_RES_XLATE) else $error("bad type not faulted");
  chk_l2_pulse: assert property (l2_req |-> done
    && desc_q[1:0] == 2'h1) else $error("wrong second-level request");
  chk_dom_field: assert property (done && ^desc_q[1:0]
    |-> domain == desc_q[8:5]) else $error("wrong domain index");
  chk_l2_base: assert property (l2_req
    |-> l2_base == desc_q[31:10]) else $error("wrong page table base");
  chk_cb_bits: assert property (done && desc_q[1:0] == 2'h2
    |-> {cacheable, bufferable} == desc_q[3:2]) else $error("wrong C/B");
  // Core may move va in the done cycle; the offset was taken one edge back
  chk_sect_pa: assert property (done && desc_q[1:0] == 2'h2
    |-> pa == {desc_q[31:20], $past(va[19:0])})
    else $error("wrong section pa");
  chk_done_bound: assert property ($rose(busy) |-> ##[3:8] done)
    else $error("walk did not finish");
  chk_done_pulse: assert property (done |=> !done)
    else $error("done held longer than one cycle");
endmodule // mlw_walk_chk

bind mlw_walk mlw_walk_chk mlw_walk_chk_i (.clk, .reset, .table_base_reg,
  .lookup_valid, .tlb_hit, .va, .busy, .mem_req, .mem_waddr, .mem_ack,
  .mem_rdata, .done, .result, .domain, .cacheable, .bufferable, .pa,
  .l2_req, .l2_base);

// File: testbench/testbench.sv
// Self-checking bench for the level-one walk.
// Assumes the memory model stands on the fetch side.
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, reset = 1'b1, table_base_we = 1'b0, lookup_valid = 1'b0;
  logic tlb_hit = 1'b0, priv = 1'b0, write = 1'b0;
  logic [31:0] table_base_wdata = 32'h0, domain_access = 32'h0;
  logic [31:0] control = 32'h0, va = 32'h0, desc = 32'h0;
  logic [1:0]  lag = 2'h0;
  logic [31:0] table_base_reg, mem_rdata, pa;
  logic busy, mem_req, mem_ack, done, cacheable, bufferable, is_section, l2_req;
  logic [29:0] mem_waddr, seen_addr;
  logic [1:0]  result;
  logic [3:0]  domain;
  logic [21:0] l2_base;
  int failures = 0, n_checks = 0;
  // Base written in t_base with its low 14 bits forced to zero
  localparam logic [31:0] BASE_EXP = 32'hABCD_4000;

  mlw_walk mlw_walk_i (.clk, .reset, .table_base_we, .table_base_wdata,
    .table_base_reg, .domain_access, .control, .lookup_valid, .tlb_hit, .va,
    .priv, .write, .busy, .mem_req, .mem_waddr, .mem_ack, .mem_rdata, .done,
    .result, .domain, .cacheable, .bufferable, .pa, .is_section, .l2_req,
    .l2_base);
  mlw_mem_model mlw_mem_model_i (.clk, .mem_req, .mem_waddr, .desc, .lag,
    .mem_ack, .seen_addr, .mem_rdata);

  initial forever #10 clk = ~clk;

  task finish_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task check(input string name, input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("[ERR] %s exp %h seen %h", name, exp, seen);
    end
  endtask

  task wait_done;
    for (int i = 0; i < 20 && done !== 1'b1; i++)
      @(negedge clk);
    if (done !== 1'b1)
    begin
      failures++;
      finish_test();
    end
  endtask

  function automatic mlw_pkg::mlw_res_t exp_res(input logic [1:0] ty, dm,
    ap, sr, input logic pv, wr);
    logic ok;
    if (ty == 2'h0 || ty == 2'h3)
      return mlw_pkg::MLW_RES_XLATE;
    if (ty == 2'h1)
      return mlw_pkg::MLW_RES_OK;
    if (!dm[0])
      return mlw_pkg::MLW_RES_DOMAIN;
    if (dm[1])
      return mlw_pkg::MLW_RES_OK;
    case (ap)
      2'h0: ok = (sr == 2'h1) ? pv && !wr : sr == 2'h2 && !wr;
      2'h1: ok = pv;
      2'h2: ok = pv || !wr;
      default: ok = 1'b1;
    endcase
    return ok ? mlw_pkg::MLW_RES_OK : mlw_pkg::MLW_RES_PERM;
  endfunction

  task t_base;
    check("base_rst", table_base_reg, mlw_pkg::TTB_RESET);
    table_base_wdata = 32'hABCD_7FFF;
    table_base_we = 1'b1;
    @(negedge clk);
    table_base_we = 1'b0;
    check("base", table_base_reg, BASE_EXP);
  endtask

  task t_hit;
    lookup_valid = 1'b1;
    tlb_hit = 1'b1;
    repeat (3) @(negedge clk);
    check("hit", 32'({busy, mem_req}), 32'h0);
    lookup_valid = 1'b0;
    tlb_hit = 1'b0;
  endtask

  task automatic walk(input logic [1:0] ty, dm, ap, sr, input logic pv, wr,
    input int n);
    logic [3:0] idx;
    logic [29:0] wa_exp;
    mlw_pkg::mlw_res_t e;
    idx = n[3:0];
    va = {n[11:0], 20'h5A5A5};
    desc = {~n[11:0], 8'h00, ap, 1'b0, idx, 1'b1,
      (ty == 2'h2) ? n[1:0] : 2'h0, ty};
    domain_access = {16{~dm}};
    domain_access[2*idx +: 2] = dm;
    control = {22'h0, sr, 8'h00};
    priv = pv;
    write = wr;
    lag = 2'(n % 3);
    e = exp_res(ty, dm, ap, sr, pv, wr);
    wa_exp = {BASE_EXP[31:14], va[31:20]};
    lookup_valid = 1'b1;
    @(negedge clk);
    lookup_valid = 1'b0;
    wait_done();
    check("result", 32'(result), 32'(e));
    check("waddr", 32'(seen_addr), 32'(wa_exp));
    check("sect", 32'(is_section), 32'(ty == 2'h2));
    if (^ty)
      check("domain", 32'(domain), 32'(idx));
    if (ty == 2'h1)
      check("l2", 32'({l2_req, l2_base}), 32'({1'b1, desc[31:10]}));
    else
      check("l2_req", 32'(l2_req), 32'h0);
    check("cb", 32'({cacheable, bufferable}),
      (ty == 2'h2) ? 32'(desc[3:2]) : 32'h0);
    if (ty == 2'h2 && e == mlw_pkg::MLW_RES_OK)
    begin
      check("pa", pa, {desc[31:20], va[19:0]});
    end
    @(negedge clk);
  endtask

  initial
  begin
    repeat (12) @(negedge clk);
    reset = 1'b0;
    t_base();
    t_hit();
    for (int t = 0; t < 4; t++)
      walk(2'(t), 2'h1, 2'h3, 2'h0, 1'b1, 1'b0, t);
    for (int d = 0; d < 4; d++)
      walk(2'h2, 2'(d), 2'h0, 2'h0, 1'b0, 1'b1, d + 4);
    for (int k = 0; k < 64; k++)
      walk(2'h2, 2'h1, 2'(k >> 4), 2'(k >> 2), k[1], k[0], k + 8);
    finish_test();
  end
endmodule // testbench

// File: verilog/mlw_fetch_port.sv
// Table memory fetch port: holds one read request until memory answers.
// Assumes memory answers with mem_ack and data in the same cycle.
module mlw_fetch_port
(
  input  wire logic        clk,
  input  wire logic        reset,
  mlw_fetch_if.port        f,
  output logic             mem_req,
  output logic [29:0]      mem_waddr,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata
);
  logic        busy_r,  busy_nxt;
  logic [29:0] addr_r,  addr_nxt;
  logic [31:0] data_r,  data_nxt;
  logic        done_r,  done_nxt;

  always_comb
  begin
    busy_nxt = busy_r;
    addr_nxt = addr_r;
    data_nxt = data_r;
    done_nxt = 1'b0;
    if (!busy_r && f.req)
    begin
      busy_nxt = 1'b1;
      addr_nxt = f.waddr;
    end
    else if (busy_r && mem_ack)
    begin
      busy_nxt = 1'b0;
      data_nxt = mem_rdata;
      done_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      busy_r <= 1'b0;
      addr_r <= 30'h0000_0000;
      data_r <= 32'h0000_0000;
      done_r <= 1'b0;
    end
    else
    begin
      busy_r <= busy_nxt;
      addr_r <= addr_nxt;
      data_r <= data_nxt;
      done_r <= done_nxt;
    end
  end

  assign mem_req   = busy_r;
  assign mem_waddr = addr_r;
  assign f.done    = done_r;
  assign f.data    = data_r;
endmodule // mlw_fetch_port

// File: verilog/mlw_walk.sv
// Level-one translation table walk: fetch, decode and section checks.
// Assumes the core holds va, priv and write stable while busy.
//
// Contract
// - Walk starts only on TLB miss
// - Table base low 14 bits read zero
// - Fetch address is base 31:14, VA 31:20
// - Type 00 invalid, 01 page, 10 section
// - Page descriptor requests second-level fetch
// - Bits 8:5 select one of sixteen domains
// - Page table base from bits 31:10
// - Section bit 3 cacheable, bit 2 bufferable
// - Section PA 31:20 from descriptor, offset passes
// - Permission bits apply only for client domains
// - Code 00: none, or system read-only
// - Code 00 ROM: reads only; both set reserved
// - Code 01: supervisor only
// - Code 10: user writes fault
// - Code 11: full access both modes
// - Domain 00 none (fault), 01 client, 10 reserved (fault), 11 manager
module mlw_walk
(
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        table_base_we,
  input  wire logic [31:0] table_base_wdata,
  output logic [31:0]      table_base_reg,
  input  wire logic [31:0] domain_access,
  input  wire logic [31:0] control,
  input  wire logic        lookup_valid,
  input  wire logic        tlb_hit,
  input  wire logic [31:0] va,
  input  wire logic        priv,
  input  wire logic        write,
  output logic             busy,
  output logic             mem_req,
  output logic [29:0]      mem_waddr,
  input  wire logic        mem_ack,
  input  wire logic [31:0] mem_rdata,
  output logic             done,
  output logic [1:0]       result,
  output logic [3:0]       domain,
  output logic             cacheable,
  output logic             bufferable,
  output logic [31:0]      pa,
  output logic             is_section,
  output logic             l2_req,
  output logic [21:0]      l2_base
);
  typedef enum logic [2:0] {
    MLW_IDLE   = 3'h1,
    MLW_FETCH  = 3'h2,
    MLW_DECODE = 3'h4
  } mlw_state_t;

  mlw_state_t  st_r, st_nxt;
  logic [31:0] ttb_r, ttb_nxt;
  logic        done_r, done_nxt;
  logic [1:0]  res_r, res_nxt;
  logic [3:0]  dom_r, dom_nxt;
  logic        c_r, c_nxt, b_r, b_nxt;
  logic [31:0] pa_r, pa_nxt;
  logic        sect_r, sect_nxt;
  logic        l2_r, l2_nxt;
  logic [21:0] l2b_r, l2b_nxt;
  logic        req;

  mlw_fetch_if fif ();

  mlw_fetch_port u_port
  (
    .clk       (clk),
    .reset     (reset),
    .f         (fif),
    .mem_req   (mem_req),
    .mem_waddr (mem_waddr),
    .mem_ack   (mem_ack),
    .mem_rdata (mem_rdata)
  );

  // Section permission check; reserved S=R=1 denies all to stay safe
  function automatic logic perm_ok(input logic [1:0] ap,
                                   input logic sys_b, input logic rom_b,
                                   input logic pv, input logic wr);
    logic ok;
    ok = 1'b0;
    unique case (ap)
      mlw_pkg::MLW_AP_00:
        if (sys_b && !rom_b)
          ok = pv && !wr;
        else if (rom_b && !sys_b)
          ok = !wr;
        else
          ok = 1'b0;
      mlw_pkg::MLW_AP_01: ok = pv;
      mlw_pkg::MLW_AP_10: ok = pv || !wr;
      mlw_pkg::MLW_AP_11: ok = 1'b1;
    endcase
    return ok;
  endfunction

  logic [31:0] d;
  logic [3:0]  dsel;
  logic [1:0]  dfield;
  assign d      = fif.data;
  assign dsel   = d[mlw_pkg::DOM_HI:mlw_pkg::DOM_LO];
  assign dfield = domain_access[{dsel, 1'b0} +: 2];

  always_comb
  begin
    st_nxt   = st_r;
    ttb_nxt  = ttb_r;
    done_nxt = 1'b0;
    l2_nxt   = 1'b0;
    res_nxt  = res_r;
    dom_nxt  = dom_r;
    c_nxt    = c_r;
    b_nxt    = b_r;
    pa_nxt   = pa_r;
    sect_nxt = sect_r;
    l2b_nxt  = l2b_r;
    req      = 1'b0;
    if (table_base_we)
      ttb_nxt = {table_base_wdata[31:mlw_pkg::BASE_LO],
                 {mlw_pkg::BASE_LO{1'b0}}};
    unique case (st_r)
      MLW_IDLE:
        if (lookup_valid && !tlb_hit)
        begin
          req    = 1'b1;
          st_nxt = MLW_FETCH;
        end
      MLW_FETCH:
        if (fif.done)
          st_nxt = MLW_DECODE;
      MLW_DECODE:
      begin
        st_nxt   = MLW_IDLE;
        done_nxt = 1'b1;
        dom_nxt  = dsel;
        sect_nxt = 1'b0;
        c_nxt    = 1'b0;
        b_nxt    = 1'b0;
        unique case (d[mlw_pkg::TYPE_HI:0])
          mlw_pkg::MLW_DESC_PAGE:
          begin
            res_nxt = mlw_pkg::MLW_RES_OK;
            l2_nxt  = 1'b1;
            l2b_nxt = d[31:mlw_pkg::PT_BASE_LO];
          end
          mlw_pkg::MLW_DESC_SECTION:
          begin
            sect_nxt = 1'b1;
            c_nxt    = d[mlw_pkg::CACHE_BIT];
            b_nxt    = d[mlw_pkg::BUF_BIT];
            pa_nxt   = {d[31:mlw_pkg::SECT_LO],
                        va[mlw_pkg::SECT_LO-1:0]};
            unique case (dfield)
              mlw_pkg::MLW_DOM_CLIENT:
                res_nxt = perm_ok(d[mlw_pkg::AP_HI:mlw_pkg::AP_LO],
                                  control[mlw_pkg::SYS_BIT],
                                  control[mlw_pkg::ROM_BIT],
                                  priv, write)
                          ? mlw_pkg::MLW_RES_OK
                          : mlw_pkg::MLW_RES_PERM;
              mlw_pkg::MLW_DOM_MANAGER:
                res_nxt = mlw_pkg::MLW_RES_OK;
              default:
                res_nxt = mlw_pkg::MLW_RES_DOMAIN;
            endcase
          end
          default:
            res_nxt = mlw_pkg::MLW_RES_XLATE;
        endcase
      end
      default:
        st_nxt = MLW_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      st_r   <= MLW_IDLE;
      ttb_r  <= mlw_pkg::TTB_RESET;
      done_r <= 1'b0;
      res_r  <= mlw_pkg::MLW_RES_OK;
      dom_r  <= 4'h0;
      c_r    <= 1'b0;
      b_r    <= 1'b0;
      pa_r   <= 32'h0000_0000;
      sect_r <= 1'b0;
      l2_r   <= 1'b0;
      l2b_r  <= 22'h00_0000;
    end
    else
    begin
      st_r   <= st_nxt;
      ttb_r  <= ttb_nxt;
      done_r <= done_nxt;
      res_r  <= res_nxt;
      dom_r  <= dom_nxt;
      c_r    <= c_nxt;
      b_r    <= b_nxt;
      pa_r   <= pa_nxt;
      sect_r <= sect_nxt;
      l2_r   <= l2_nxt;
      l2b_r  <= l2b_nxt;
    end
  end

  assign fif.req   = req;
  assign fif.waddr = {ttb_r[31:mlw_pkg::BASE_LO],
                      va[31:mlw_pkg::VA_IDX_LO]};

  assign table_base_reg = ttb_r;
  assign busy           = (st_r != MLW_IDLE);
  assign done           = done_r;
  assign result         = res_r;
  assign domain         = dom_r;
  assign cacheable      = c_r;
  assign bufferable     = b_r;
  assign pa             = pa_r;
  assign is_section     = sect_r;
  assign l2_req         = l2_r;
  assign l2_base        = l2b_r;
endmodule // mlw_walk
